// ---- uac_consts.vh ----
// Constants for the serial message framer
`ifndef UAC_CONSTS_VH
`define UAC_CONSTS_VH
`define UAC_MODE_PLAIN   2'h1
`define UAC_MODE_ESC     2'h2
`define UAC_DELIM        8'h7E
`define UAC_ESC_MARK     8'h7D
`define UAC_XON          8'h11
`define UAC_XOFF         8'h13
`define UAC_ESC_XOR      8'h20
`define UAC_CSUM_GOOD    8'hFF
`define UAC_ID_STATUS    8'h8A
`define UAC_ID_CMD       8'h08
`define UAC_ID_CMD_RESP  8'h88
`define UAC_ID_TX_REQ    8'h02
`define UAC_ID_TX_STAT   8'h8B
`define UAC_ID_RX_PKT    8'h82
`define UAC_ST_LEN       16'h0002
`define UAC_ST_BAD_CSUM  8'h01
`define UAC_ST_BAD_LEN   8'h02
`define UAC_ST_ABORT     8'h03
`define UAC_FIFO_DEPTH   4
`endif

// ---- uac_fifo.v ----
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module uac_fifo #(
  parameter W = 9,
  parameter D = 4
) (
  input  wire         clk_sys,
  input  wire         rst,
  input  wire         clk_en,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  localparam AW = (D > 1) ? $clog2(D) : 1;
  reg [W-1:0]  mem [0:D-1];   // Storage words
  reg [AW-1:0] wp_q;          // Write pointer
  reg [AW-1:0] rp_q;          // Read pointer
  reg [AW:0]   cnt_q;         // Fill level
  wire push;
  wire pop;
  assign in_ready  = clk_en & (cnt_q != D[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rp_q];
  assign push = in_valid & in_ready;
  assign pop  = clk_en & out_valid & out_ready;
  // Storage has no reset; only pointers and fill level need a defined value
  always @(posedge clk_sys) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end
  // Pointers wrap at the depth, which need not be a power of two
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (clk_en) begin
      if (push) begin
        wp_q <= (wp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- uac_codec.v ----
// Serial message framer: frame decoder, encoder and transparent path
`timescale 1ns/100ps
`default_nettype none
`include "uac_consts.vh"
module uac_codec (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        clk_en,
  input  wire [1:0]  api_mode_select,
  input  wire        rx_valid,
  output wire        rx_ready,
  input  wire [7:0]  serial_data_in,
  output wire        msg_valid,
  input  wire        msg_ready,
  output wire [7:0]  msg_data,
  output wire        msg_last,
  output reg  [7:0]  msg_type_q,
  output reg         frame_ok_q,
  output reg         frame_err_q,
  output reg         tx_req_seen_q,
  input  wire        om_valid,
  output reg         om_ready,
  input  wire [7:0]  om_data,
  input  wire [15:0] om_len,
  output reg         tx_valid_q,
  input  wire        tx_ready,
  output reg  [7:0]  serial_data_out_q
);
  // Decoder states, one-hot
  localparam D_IDLE = 5'h01;
  localparam D_LENH = 5'h02;
  localparam D_LENL = 5'h04;
  localparam D_DATA = 5'h08;
  localparam D_CSUM = 5'h10;
  // Encoder states, one-hot
  localparam E_IDLE = 5'h01;
  localparam E_LENH = 5'h02;
  localparam E_LENL = 5'h04;
  localparam E_BODY = 5'h08;
  localparam E_CSUM = 5'h10;
  // Reserved byte check, used by the encoder only
  function needs_esc;
    input [7:0] b;
    begin
      needs_esc = (b == `UAC_DELIM) | (b == `UAC_ESC_MARK) |
                  (b == `UAC_XON) | (b == `UAC_XOFF);
    end
  endfunction
  // Mode decode
  wire api_on = (api_mode_select == `UAC_MODE_PLAIN) |
                (api_mode_select == `UAC_MODE_ESC);
  wire esc_on = (api_mode_select == `UAC_MODE_ESC);
  // Decoder state
  reg [4:0]  dst_q;      // Decoder state
  reg        desc_q;     // Escape marker seen
  reg [7:0]  dlen_hi_q;  // Length high byte
  reg [15:0] dlen_q;     // Payload length
  reg [15:0] dcnt_q;     // Payload bytes taken
  reg [7:0]  dsum_q;     // Running sum
  // Shared status-frame request
  reg        err_pend_q; // Status frame owed to host
  reg [7:0]  err_code_q; // Failure kind
  reg        err_set;    // Decoder raises failure
  reg [7:0]  err_code;   // Failure kind this cycle
  reg        err_clr;    // Encoder takes the request
  // Encoder state
  reg [4:0]  est_q;      // Encoder state
  reg        int_q;      // Sending own status frame
  reg [7:0]  st_code_q;  // Snapshot of failure kind
  reg [15:0] elen_q;     // Length being sent
  reg [15:0] ecnt_q;     // Body bytes sent
  reg [7:0]  esum_q;     // Body sum
  reg        epend_q;    // Escaped byte still owed
  reg [7:0]  ebyte_q;    // Transformed byte owed
  reg        emit_en;    // A byte leaves this cycle
  reg [7:0]  emit_b;     // Unescaped byte value
  reg        emit_raw;   // Byte bypasses escaping
  wire       tx_free;
  wire       go;
  // Receive-side helpers
  wire       f_in_ready;
  wire [7:0] rx_val = desc_q ? (serial_data_in ^ `UAC_ESC_XOR)
                             : serial_data_in;
  // In plain mode a 0x7E inside a frame is data; escaped mode never has one
  wire restart = api_on & (serial_data_in == `UAC_DELIM) &
                 (esc_on | (dst_q == D_IDLE));
  wire is_mark = esc_on & ~desc_q & (serial_data_in == `UAC_ESC_MARK);
  wire in_data = ~api_on | (dst_q == D_DATA);
  assign rx_ready = clk_en & (in_data ? f_in_ready : 1'b1);
  wire rx_take = rx_valid & rx_ready;
  wire d_last  = (dcnt_q == dlen_q - 16'h0001);
  wire f_push  = rx_take & (~api_on | ((dst_q == D_DATA) & ~restart & ~is_mark)); // Framed modes push payload bytes only, not escape marks or restart delimiters
  wire [8:0] f_din = api_on ? {d_last, rx_val} : {1'b0, serial_data_in};
  // Payload buffer toward the message consumer; back-pressure stalls input
  uac_fifo #(
    .W (9),
    .D (`UAC_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .clk_en    (clk_en),
    .in_valid  (f_push),
    .in_ready  (f_in_ready),
    .in_data   (f_din),
    .out_valid (msg_valid),
    .out_ready (msg_ready),
    .out_data  ({msg_last, msg_data})
  );
  // Failure detection from the decoder, combinational
  always @* begin
    err_set  = 1'b0;
    err_code = `UAC_ST_ABORT;
    if (rx_take & api_on) begin
      if (restart) begin
        // Partial frame abandoned, reported as aborted
        err_set  = (dst_q != D_IDLE);
        err_code = `UAC_ST_ABORT;
      end else if (~is_mark & (dst_q == D_LENL) &
                   ({dlen_hi_q, rx_val} == 16'h0000)) begin
        err_set  = 1'b1;
        err_code = `UAC_ST_BAD_LEN;
      end else if (~is_mark & (dst_q == D_CSUM) &
                   ((dsum_q + rx_val) != `UAC_CSUM_GOOD)) begin
        err_set  = 1'b1;
        err_code = `UAC_ST_BAD_CSUM;
      end
    end
  end
  // Frame decoder
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dst_q         <= D_IDLE;
      desc_q        <= 1'b0;
      dlen_hi_q     <= 8'h00;
      dlen_q        <= 16'h0000;
      dcnt_q        <= 16'h0000;
      dsum_q        <= 8'h00;
      msg_type_q    <= 8'h00;
      frame_ok_q    <= 1'b0;
      frame_err_q   <= 1'b0;
      tx_req_seen_q <= 1'b0;
    end else if (clk_en) begin
      frame_ok_q    <= 1'b0;
      frame_err_q   <= err_set;
      tx_req_seen_q <= 1'b0;
      if (~api_on) begin
        // Transparent: no framing state kept
        dst_q  <= D_IDLE;
        desc_q <= 1'b0;
      end else if (rx_take) begin
        if (restart) begin
          dst_q  <= D_LENH;
          desc_q <= 1'b0;
        end else if (is_mark) begin
          desc_q <= 1'b1;
        end else begin
          desc_q <= 1'b0;
          case (dst_q)
            D_IDLE: begin
              // Bytes before a delimiter are dropped
              dst_q <= D_IDLE;
            end
            D_LENH: begin
              dlen_hi_q <= rx_val;
              dst_q     <= D_LENL;
            end
            D_LENL: begin
              dlen_q <= {dlen_hi_q, rx_val};
              dcnt_q <= 16'h0000;
              dsum_q <= 8'h00;
              dst_q  <= ({dlen_hi_q, rx_val} == 16'h0000) ? D_IDLE : D_DATA;
            end
            D_DATA: begin
              if (dcnt_q == 16'h0000) begin
                msg_type_q <= rx_val;
              end
              dsum_q <= dsum_q + rx_val;
              dcnt_q <= dcnt_q + 16'h0001;
              if (d_last) begin
                dst_q <= D_CSUM;
              end
            end
            D_CSUM: begin
              dst_q <= D_IDLE;
              if ((dsum_q + rx_val) == `UAC_CSUM_GOOD) begin
                frame_ok_q    <= 1'b1;
                // Core launches the radio packet on this pulse
                tx_req_seen_q <= (msg_type_q == `UAC_ID_TX_REQ);
              end
            end
            default: begin
              dst_q <= D_IDLE;
            end
          endcase
        end
      end
    end
  end
  // Pending status frame; a new failure wins over the take
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      err_pend_q <= 1'b0;
      err_code_q <= 8'h00;
    end else if (clk_en) begin
      if (err_set) begin
        err_pend_q <= 1'b1;
        err_code_q <= err_code;
      end else if (err_clr) begin
        err_pend_q <= 1'b0;
      end
    end
  end
  // Encoder output slot
  assign tx_free = ~tx_valid_q | tx_ready;
  assign go      = clk_en & tx_free;
  // Encoder byte selection
  always @* begin
    emit_en  = 1'b0;
    emit_b   = 8'h00;
    emit_raw = 1'b0;
    om_ready = 1'b0;
    err_clr  = 1'b0;
    if (go) begin
      if (epend_q) begin
        // Second half of an escape pair
        emit_en  = 1'b1;
        emit_b   = ebyte_q;
        emit_raw = 1'b1;
      end else begin
        case (est_q)
          E_IDLE: begin
            if (~api_on) begin
              // Core bytes go out unaltered
              emit_en  = om_valid;
              emit_b   = om_data;
              emit_raw = 1'b1;
              om_ready = 1'b1;
            end else if (err_pend_q | om_valid) begin
              emit_en  = 1'b1;
              emit_b   = `UAC_DELIM;
              emit_raw = 1'b1;
              err_clr  = err_pend_q;
            end
          end
          E_LENH: begin
            emit_en = 1'b1;
            emit_b  = elen_q[15:8];
          end
          E_LENL: begin
            emit_en = 1'b1;
            emit_b  = elen_q[7:0];
          end
          E_BODY: begin
            // Own status frame: identifier then failure kind
            if (int_q) begin
              emit_en = 1'b1;
              emit_b  = (ecnt_q == 16'h0000) ? `UAC_ID_STATUS : st_code_q;
            end else begin
              // Core frames carry 0x88, 0x8B, 0x82 identifiers as given
              emit_en  = om_valid;
              emit_b   = om_data;
              om_ready = 1'b1;
            end
          end
          E_CSUM: begin
            emit_en = 1'b1;
            emit_b  = `UAC_CSUM_GOOD - esum_q;
          end
          default: begin
            emit_en = 1'b0;
          end
        endcase
      end
    end
  end
  // Encoder sequencing and escaping
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      est_q             <= E_IDLE;
      int_q             <= 1'b0;
      st_code_q         <= 8'h00;
      elen_q            <= 16'h0000;
      ecnt_q            <= 16'h0000;
      esum_q            <= 8'h00;
      epend_q           <= 1'b0;
      ebyte_q           <= 8'h00;
      tx_valid_q        <= 1'b0;
      serial_data_out_q <= 8'h00;
    end else if (go) begin
      tx_valid_q <= emit_en;
      epend_q    <= 1'b0;
      if (emit_en) begin
        if (esc_on & ~emit_raw & needs_esc(emit_b)) begin
          serial_data_out_q <= `UAC_ESC_MARK;
          epend_q           <= 1'b1;
          ebyte_q           <= emit_b ^ `UAC_ESC_XOR;
        end else begin
          serial_data_out_q <= emit_b;
        end
      end
      if (emit_en & ~epend_q) begin
        case (est_q)
          E_IDLE: begin
            if (api_on) begin
              int_q     <= err_pend_q;
              st_code_q <= err_code_q;
              elen_q    <= err_pend_q ? `UAC_ST_LEN : om_len;
              est_q     <= E_LENH;
            end
          end
          E_LENH: begin
            est_q <= E_LENL;
          end
          E_LENL: begin
            ecnt_q <= 16'h0000;
            esum_q <= 8'h00;
            est_q  <= (elen_q == 16'h0000) ? E_CSUM : E_BODY;
          end
          E_BODY: begin
            esum_q <= esum_q + emit_b;
            ecnt_q <= ecnt_q + 16'h0001;
            if (ecnt_q == elen_q - 16'h0001) begin
              est_q <= E_CSUM;
            end
          end
          E_CSUM: begin
            est_q <= E_IDLE;
          end
          default: begin
            est_q <= E_IDLE;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- uac_host.sv ----
// Host model: frames bytes into the codec, collects what it sends
`timescale 1ns/100ps
`default_nettype none
module uac_host (
  input  wire logic       clk_sys,
  output var  logic       rx_valid,
  input  wire logic       rx_ready,
  output var  logic [7:0] serial_data_in,
  input  wire logic       tx_valid_q,
  output var  logic       tx_ready,
  input  wire logic [7:0] serial_data_out_q
);
  logic [7:0] txq[$]; // Bytes taken from the codec
  logic       slow;   // Stall the transmit side
  int         hung;   // Waits that ran out
  initial begin
    rx_valid = 1'b0;
    serial_data_in = 8'h00;
    tx_ready = 1'b1;
    slow = 1'b0;
    hung = 0;
  end
  // Collect bytes; a slow host drops ready every other cycle
  always @(posedge clk_sys) begin
    if (tx_valid_q && tx_ready) begin
      txq.push_back(serial_data_out_q);
    end
    tx_ready <= #1 slow ? !tx_ready : 1'b1;
  end
  // Bytes back to back, each held until taken
  task automatic raw(input logic [7:0] q[$]);
    logic r;
    int   n;
    foreach (q[i]) begin
      #1;
      rx_valid = 1'b1;
      serial_data_in = q[i];
      n = 0;
      do begin
        @(negedge clk_sys);
        r = rx_ready;
        @(posedge clk_sys);
        n++;
      end while (!r && n < 500);
      hung += !r;
    end
    #1;
    rx_valid = 1'b0;
    serial_data_in = ~serial_data_in; // Idle line shows no stale byte
    @(posedge clk_sys);
  endtask
  // Frame n bytes of p, first byte highest
  task automatic frame(input bit esc, input logic [63:0] p, input int n, input logic [7:0] bad);
    logic [7:0] b[$];
    logic [7:0] q[$];
    logic [7:0] s;
    b = {8'h00, 8'(n)};
    s = 8'h00;
    for (int i = n - 1; i >= 0; i--) begin
      b.push_back(p[i*8 +: 8]);
      s += p[i*8 +: 8];
    end
    b.push_back((8'hFF - s) ^ bad);
    q = {8'h7E};
    foreach (b[i]) begin
      if (esc && b[i] inside {8'h7E, 8'h7D, 8'h11, 8'h13}) begin
        q.push_back(8'h7D);
        q.push_back(b[i] ^ 8'h20);
      end else begin
        q.push_back(b[i]);
      end
    end
    raw(q);
  endtask
endmodule
`default_nettype wire

// ---- uac_codec_assertions.sv ----
// Port checks for the serial message codec
`timescale 1ns/100ps
`default_nettype none
`include "uac_consts.vh"
module uac_chk (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [1:0] api_mode_select,
  input wire logic       msg_valid,
  input wire logic       msg_ready,
  input wire logic [7:0] msg_data,
  input wire logic [7:0] msg_type_q,
  input wire logic       frame_ok_q,
  input wire logic       frame_err_q,
  input wire logic       tx_req_seen_q,
  input wire logic       tx_valid_q,
  input wire logic       tx_ready,
  input wire logic [7:0] serial_data_out_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Escape marker handed over; a flag, so the sequence below may combine it
  wire s_sent_b = tx_valid_q && tx_ready && serial_data_out_q == `UAC_ESC_MARK;
  // One byte handed to the transmitter
  sequence s_sent(b);
    tx_valid_q && tx_ready && serial_data_out_q == b;
  endsequence
  // Receive failure in a framed mode
  sequence s_fail;
    frame_err_q && api_mode_select inside {`UAC_MODE_PLAIN, `UAC_MODE_ESC};
  endsequence
  // Escape marker leaving in escaped mode
  sequence s_mark;
    api_mode_select == `UAC_MODE_ESC && s_sent_b;
  endsequence
  ok_err_excl_a:
    assert property (frame_ok_q |-> !frame_err_q) else $error("ok with error");
  tx_req_type_a:
    assert property (tx_req_seen_q |-> frame_ok_q && msg_type_q == `UAC_ID_TX_REQ) else $error("bad request flag");
  err_delim_a:
    assert property (s_fail |-> ##[1:200] s_sent(`UAC_DELIM)) else $error("no status frame");
  err_status_a:
    assert property (s_fail |-> ##[1:200] s_sent(`UAC_ID_STATUS)) else $error("no status type");
  esc_pair_a:
    assert property (s_mark |=> tx_valid_q && serial_data_out_q inside {8'h5E, 8'h5D, 8'h31, 8'h33})
      else $error("bad escape pair");
  no_flow_raw_a:
    assert property (api_mode_select == `UAC_MODE_ESC && tx_valid_q |-> !(serial_data_out_q inside {8'h11, 8'h13}))
      else $error("flow byte sent raw");
  tx_hold_a:
    assert property (tx_valid_q && !tx_ready |=> tx_valid_q && $stable(serial_data_out_q)) else $error("tx byte lost");
  msg_hold_a:
    assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_data)) else $error("msg byte lost");
endmodule
bind uac_codec uac_chk u_chk (
  .clk_sys(clk_sys), .rst(rst), .api_mode_select(api_mode_select), .msg_valid(msg_valid),
  .msg_ready(msg_ready), .msg_data(msg_data), .msg_type_q(msg_type_q), .frame_ok_q(frame_ok_q),
  .frame_err_q(frame_err_q), .tx_req_seen_q(tx_req_seen_q), .tx_valid_q(tx_valid_q),
  .tx_ready(tx_ready), .serial_data_out_q(serial_data_out_q)
);
`default_nettype wire

// ---- uart_api_frame_codec_tb.sv ----
// Testbench for the serial message codec
`timescale 1ns/100ps
`default_nettype none
`include "uac_consts.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; $display("BAD %0t got %h exp %h", $time, a, b); end end
module uart_api_frame_codec_tb;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;               // Low freezes the codec
  logic [1:0]  mode = `UAC_MODE_PLAIN;
  logic        msg_ready = 1'b1;
  logic        om_valid = 1'b0;
  logic [7:0]  om_data = 8'h00;
  logic [15:0] om_len = 16'h0000;
  wire logic   rx_valid, rx_ready, msg_valid, msg_last, om_ready, tx_valid_q, tx_ready;
  wire logic   frame_ok_q, frame_err_q, tx_req_seen_q;
  wire logic [7:0] serial_data_in, msg_data, msg_type_q, serial_data_out_q;
  int          errors = 0;
  int          total_checks = 0;
  int          nok = 0, nerr = 0, nreq = 0; // Pulses seen per scenario
  logic [8:0]  mq[$];                       // Popped bytes with last flag
  bit          full_seen;                   // Receive side refused a byte
  always #2.5 clk_sys = ~clk_sys;
  uac_codec uut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .api_mode_select(mode), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .serial_data_in(serial_data_in), .msg_valid(msg_valid), .msg_ready(msg_ready),
    .msg_data(msg_data), .msg_last(msg_last), .msg_type_q(msg_type_q), .frame_ok_q(frame_ok_q),
    .frame_err_q(frame_err_q), .tx_req_seen_q(tx_req_seen_q), .om_valid(om_valid), .om_ready(om_ready),
    .om_data(om_data), .om_len(om_len), .tx_valid_q(tx_valid_q), .tx_ready(tx_ready),
    .serial_data_out_q(serial_data_out_q));
  uac_host host (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_ready(rx_ready), .serial_data_in(serial_data_in),
    .tx_valid_q(tx_valid_q), .tx_ready(tx_ready), .serial_data_out_q(serial_data_out_q));
  // Watch outputs at each edge
  always @(posedge clk_sys) begin
    if (msg_valid && msg_ready) mq.push_back({msg_last, msg_data});
    nok += frame_ok_q;
    nerr += frame_err_q;
    nreq += tx_req_seen_q;
    if (rx_valid && !rx_ready) full_seen = 1'b1;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Scenario setup, settled before the next edge
  task automatic start(input logic [1:0] m, input bit r, input bit s);
    @(posedge clk_sys);
    #1;
    mode = m;
    msg_ready = r;
    host.slow = s;
    full_seen = 1'b0;
    nok = 0;
    nerr = 0;
    nreq = 0;
    mq.delete();
    host.txq.delete();
    @(posedge clk_sys);
  endtask
  // Core message bytes to the transmitter
  task automatic om_send(input logic [63:0] p, input int n);
    logic r;
    int   k;
    #1;
    om_len = 16'(n);
    om_valid = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      om_data = p[i*8 +: 8];
      k = 0;
      do begin
        @(negedge clk_sys);
        r = om_ready;
        @(posedge clk_sys);
        k++;
      end while (!r && k < 400);
      `CHK(r, 1'b1)
      if (!r) finish_test();
      #1;
    end
    om_valid = 1'b0;
    @(posedge clk_sys);
  endtask
  // Wait for n sent bytes, compare, clear
  task automatic tx_is(input logic [63:0] e, input int n);
    int k;
    k = 0;
    while (host.txq.size() < n && k < 400) begin
      @(posedge clk_sys);
      k++;
    end
    `CHK(host.txq.size(), n)
    if (host.txq.size() < n) begin
      finish_test();
    end else begin
      for (int i = 0; i < n; i++) `CHK(host.txq[i], e[(n-1-i)*8 +: 8])
      host.txq.delete();
    end
  endtask
  // Compare popped bytes; last flag on the final one when framed
  task automatic msg_is(input logic [63:0] e, input int n, input bit fr);
    `CHK(mq.size(), n)
    foreach (mq[i]) `CHK(mq[i], {fr && i == n - 1, e[(n-1-i)*8 +: 8]})
  endtask
  task automatic t_plain();
    start(`UAC_MODE_PLAIN, 1'b1, 1'b0);
    host.raw({8'h55, 8'h7D, 8'h13});
    host.frame(1'b0, 64'h2311, 2, 8'h00);
    repeat (3) @(posedge clk_sys);
    msg_is(64'h2311, 2, 1'b1);
    `CHK(nok, 1);
    `CHK(msg_type_q, 8'h23);
  endtask
  // Clock enable low holds a frame in its payload state
  task automatic t_hold();
    start(`UAC_MODE_PLAIN, 1'b1, 1'b0);
    host.raw({8'h7E, 8'h00, 8'h01});
    fork
      host.raw({8'h33, 8'hCC});
      begin
        #1;
        clk_en = 1'b0;
        @(negedge clk_sys);
        `CHK(rx_ready, 1'b0);
        repeat (10) @(posedge clk_sys);
        #1;
        clk_en = 1'b1;
      end
    join
    repeat (3) @(posedge clk_sys);
    `CHK(full_seen, 1'b1);
    `CHK(nok, 1);
    msg_is(64'h33, 1, 1'b1);
  endtask
  // Bad checksum, then an empty frame
  task automatic t_fail();
    start(`UAC_MODE_PLAIN, 1'b1, 1'b0);
    host.frame(1'b0, 64'h33, 1, 8'h01);
    tx_is(64'h7E00028A0174, 6);
    host.frame(1'b0, 64'h00, 0, 8'h00);
    tx_is(64'h7E00028A0273, 6);
    `CHK(nerr, 2);
    `CHK(nok, 0);
  endtask
  // Escaped request frame into a stalled buffer
  task automatic t_esc();
    start(`UAC_MODE_ESC, 1'b0, 1'b0);
    fork
      host.frame(1'b1, 64'h027E7D1113AA, 6, 8'h00);
      begin
        repeat (30) @(posedge clk_sys);
        #1;
        msg_ready = 1'b1;
      end
    join
    repeat (3) @(posedge clk_sys);
    `CHK(full_seen, 1'b1);
    `CHK(nreq, 1);
    msg_is(64'h027E7D1113AA, 6, 1'b1);
  endtask
  // Fresh delimiter cuts a frame; parameter command follows
  task automatic t_abort();
    start(`UAC_MODE_ESC, 1'b1, 1'b0);
    host.raw({8'h7E, 8'h00, 8'h03, 8'h08});
    host.frame(1'b1, 64'h084D4E4A40, 5, 8'h00);
    repeat (3) @(posedge clk_sys);
    tx_is(64'h7E00028A0372, 6);
    `CHK(nok, 1);
    `CHK(msg_type_q, 8'h08);
  endtask
  // Core message out in both framed modes, host stalling
  task automatic t_out();
    start(`UAC_MODE_ESC, 1'b1, 1'b1);
    om_send(64'h8B11, 2);
    tx_is(64'h7E00028B7D3163, 7);
    start(`UAC_MODE_PLAIN, 1'b1, 1'b1);
    om_send(64'h8B11, 2);
    tx_is(64'h7E00028B1163, 6);
  endtask
  // Transparent mode passes bytes both ways as they are
  task automatic t_transp();
    start(2'h0, 1'b1, 1'b0);
    host.raw({8'h7E, 8'h11});
    om_send(64'h55, 1);
    repeat (3) @(posedge clk_sys);
    msg_is(64'h7E11, 2, 1'b0);
    tx_is(64'h55, 1);
    `CHK(nok + nerr, 0);
  endtask
  // Reset, scenarios, verdict
  initial begin
    repeat (6) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_plain();
    t_hold();
    t_fail();
    t_esc();
    t_abort();
    t_out();
    t_transp();
    `CHK(host.hung, 0);
    finish_test();
  end
endmodule
`default_nettype wire
